// [inc/eil_pkg.sv]
package eil_pkg;

    // Field positions inside the control and status word
    localparam int unsigned SENSE_BIT   = 0;
    localparam int unsigned MASK_BIT    = 1;
    localparam int unsigned ACK_BIT     = 2;
    localparam int unsigned PENDING_BIT = 3;
    localparam int unsigned STATUS_W    = 8;

    // Reset values of the control state
    localparam logic LATCH_RST    = 1'h0;
    localparam logic MASK_RST     = 1'h0;
    localparam logic SENSE_RST    = 1'h0;
    localparam logic ACK_HELD_RST = 1'h0;
    // The pin idles high, so the synchroniser starts high
    localparam logic PIN_IDLE     = 1'h1;

    // Number of flip-flops between the pin and any logic
    localparam int unsigned SYNC_STAGES = 2;

    // Trigger sensitivity of the external pin
    typedef enum logic
    {
        EIL_EDGE_ONLY  = 1'h0,
        EIL_EDGE_LEVEL = 1'h1
    } eil_sense_e;

endpackage : eil_pkg

// [inc/eil_if.sv]
`timescale 1ns/1ps

// Synchronised pin level and edge from the pin front end to the latch
interface eil_if;
    logic pin_level;
    logic fall_edge;

    modport src
    (
        output pin_level,
        output fall_edge
    );

    modport dst
    (
        input pin_level,
        input fall_edge
    );
endinterface : eil_if

// [design/eil_sync.sv]
`timescale 1ns/1ps

// Pin front end: two-flop synchroniser plus a history flop
module eil_sync
#(
    parameter int unsigned STAGES = eil_pkg::SYNC_STAGES
)
(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic pin_n,
    eil_if.src        edge_out
);

    logic [STAGES-1:0] sync_reg;
    logic              prev_reg;

    // Stage 0 feeds only stage 1; logic reads the last stage
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_reg <= {STAGES{eil_pkg::PIN_IDLE}};
            prev_reg <= eil_pkg::PIN_IDLE;
        end
        else
        begin
            sync_reg <= {sync_reg[STAGES-2:0], pin_n};
            prev_reg <= sync_reg[STAGES-1];
        end
    end

    // Falling edge: previous sample high, current low
    assign edge_out.pin_level = sync_reg[STAGES-1];
    assign edge_out.fall_edge = prev_reg & ~sync_reg[STAGES-1];

endmodule : eil_sync

// [design/eil_top.sv]
`timescale 1ns/1ps

// Summary of operation
// - A falling edge on the interrupt pin sets the latch and raises a request.
// - A vector fetch for this interrupt gives an acknowledge that clears the latch.
// - Writing one to the acknowledge bit acts exactly like a vector fetch.
// - Any reset clears the interrupt latch unconditionally.
// - Sense select picks edge-only or edge plus low level; edge-only after reset.
// - Edge-only mode: latch holds until acknowledge or reset, whatever the pin does.
// - Edge plus level: latch clears only after acknowledge and pin back high.
// - Edge plus level: acknowledge and pin rise in either order; early acknowledge kept.
// - Edge plus level: request stays pending while the pin is held low.
// - Reset clears latch and sense select even while the pin stays low.
// - Mask bit set withholds the latched request from the priority logic.
// - Pending flag shows the latch state regardless of the mask bit.
// - Acknowledge bit is write-only and always reads zero.
module eil_top
(
    input  wire logic                            clock,
    input  wire logic                            rstn,
    input  wire logic                            irq_pin_n,
    input  wire logic                            vector_fetch,
    input  wire logic                            cfg_write,
    input  wire logic                            cfg_ack_wdata,
    input  wire logic                            cfg_mask_wdata,
    input  wire logic                            cfg_level_wdata,
    output logic                                 ext_int_request,
    output logic                                 ext_int_pending_flag,
    output logic                                 ext_int_mask,
    output logic                                 level_sense_select,
    output logic                                 pin_level,
    output logic [eil_pkg::STATUS_W-1:0]         ext_int_ctrl_status
);

    // Control and latch state flip-flops, cleared by the system reset, each with its combinational next value
    logic                latch_reg;
    logic                latch_next;
    logic                ack_held_reg;
    logic                ack_held_next;
    logic                mask_reg;
    logic                mask_next;
    eil_pkg::eil_sense_e sense_reg;
    eil_pkg::eil_sense_e sense_next;

    // Decoded events of the current cycle
    logic                sw_ack;
    logic                ack_any;
    logic                ack_pending;
    logic                level_mode;
    logic                pin_high;
    logic                fresh_edge;
    logic                level_hold;
    logic                level_release;
    logic                edge_release;
    logic                latch_release;

    // Packed control and status word
    logic [eil_pkg::STATUS_W-1:0] status_word;

    // Synchronised pin level and edge, shared with the latch logic
    eil_if edge_bus ();

    // Pin front end; the raw pin goes nowhere else, so no logic sees a
    // metastable level straight off the pad
    // Limitation: no glitch filter, a clean pulse of two clocks is needed
    // for the edge to be seen reliably
    eil_sync
    #(
        .STAGES (eil_pkg::SYNC_STAGES)
    )
    i_eil_sync
    (
        .clock    (clock),
        .rstn     (rstn),
        .pin_n    (irq_pin_n),
        .edge_out (edge_bus.src)
    );

    // Local copies of the front-end outputs keep the decode lines short
    assign pin_high   = edge_bus.pin_level;
    assign fresh_edge = edge_bus.fall_edge;

    // Level-mode release test, shared by the latch and its assertion:
    // an acknowledge now or one remembered, and the pin back high
    function automatic logic level_clear_ok
    (
        input logic ack_now,
        input logic ack_kept,
        input logic pin_is_high
    );
        return (ack_now | ack_kept) & pin_is_high;
    endfunction : level_clear_ok

    // Both acknowledge sources merge here; a software write is treated
    // exactly like a vector fetch, so the two can never disagree
    assign sw_ack      = cfg_write & cfg_ack_wdata;
    assign ack_any     = vector_fetch | sw_ack;
    assign ack_pending = ack_any | ack_held_reg;

    // Sensitivity decode
    assign level_mode = (sense_reg == eil_pkg::EIL_EDGE_LEVEL);

    // Release terms per mode. Edge-only mode ignores the pin entirely;
    // level mode waits for both the acknowledge and the pin going high
    assign edge_release  = ~level_mode & ack_any;
    assign level_release = level_mode & level_clear_ok(ack_any, ack_held_reg, pin_high);
    assign latch_release = edge_release | level_release;

    // A low pin in level mode keeps the request alive
    assign level_hold = level_mode & ~pin_high;

    // Set terms win over release, so an edge meeting an acknowledge in
    // the same cycle is never lost
    assign latch_next = fresh_edge | level_hold | (latch_reg & ~latch_release);

    // An early acknowledge in level mode is remembered until the pin
    // rises; a fresh edge starts a new request and forgets it
    assign ack_held_next = level_mode & latch_reg & ~fresh_edge
                         & ~pin_high & ack_pending;

    // Mask and sense select load on every control write
    assign mask_next  = cfg_write ? cfg_mask_wdata : mask_reg;
    assign sense_next = cfg_write ? eil_pkg::eil_sense_e'(cfg_level_wdata) : sense_reg;

    // Latch flip-flops; reset clears them whatever the pin does
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            latch_reg    <= eil_pkg::LATCH_RST;
            ack_held_reg <= eil_pkg::ACK_HELD_RST;
        end
        else
        begin
            latch_reg    <= latch_next;
            ack_held_reg <= ack_held_next;
        end
    end

    // Control bits; sense select comes back as edge-only
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mask_reg  <= eil_pkg::MASK_RST;
            sense_reg <= eil_pkg::eil_sense_e'(eil_pkg::SENSE_RST);
        end
        else
        begin
            mask_reg  <= mask_next;
            sense_reg <= sense_next;
        end
    end

    // Request to the priority logic is withheld while masked; the
    // pending flag ignores the mask so polling software still sees it
    assign ext_int_request      = latch_reg & ~mask_reg;
    assign ext_int_pending_flag = latch_reg;
    assign ext_int_mask         = mask_reg;
    assign level_sense_select   = level_mode;
    assign pin_level            = pin_high;

    // Status word packing; the acknowledge bit has no storage behind it
    always_comb
    begin
        status_word                       = {eil_pkg::STATUS_W{1'h0}};
        status_word[eil_pkg::SENSE_BIT]   = level_mode;
        status_word[eil_pkg::MASK_BIT]    = mask_reg;
        status_word[eil_pkg::ACK_BIT]     = 1'h0;
        status_word[eil_pkg::PENDING_BIT] = latch_reg;
    end

    assign ext_int_ctrl_status = status_word;

    // Sequences for the assertions below; each names one situation of
    // the latch, so the properties read as cause and effect
    sequence s_fresh_edge;
        fresh_edge;
    endsequence : s_fresh_edge

    // Edge-only mode, latch set, acknowledge, no new edge
    sequence s_edge_ack;
        !level_mode && latch_reg && ack_any && !fresh_edge;
    endsequence : s_edge_ack

    // Edge-only mode, latch set, no acknowledge at all
    sequence s_edge_idle;
        !level_mode && latch_reg && !ack_any;
    endsequence : s_edge_idle

    // Level mode, latch set, pin still low
    sequence s_level_low;
        level_mode && latch_reg && !pin_high;
    endsequence : s_level_low

    // Level mode acknowledge arriving while the pin is still low
    sequence s_early_ack;
        s_level_low ##0 (ack_any && !fresh_edge);
    endsequence : s_early_ack

    // Level mode, pin high again and an acknowledge now or remembered
    sequence s_level_done;
        level_mode && latch_reg && !fresh_edge
            && level_clear_ok(ack_any, ack_held_reg, pin_high);
    endsequence : s_level_done

    // Any falling edge leaves the latch set, acknowledge or not
    a_edge_sets_latch : assert property
    (
        @(posedge clock) disable iff (!rstn) s_fresh_edge |=> latch_reg
    )
    else $error("falling edge did not set the latch");

    // Edge-only mode: an acknowledge clears the latch at once
    a_edge_ack_clears : assert property
    (
        @(posedge clock) disable iff (!rstn) s_edge_ack |=> !latch_reg
    )
    else $error("acknowledge did not clear the latch in edge mode");

    // Edge-only mode: without acknowledge the latch stays set
    a_edge_holds : assert property
    (
        @(posedge clock) disable iff (!rstn) s_edge_idle |=> latch_reg
    )
    else $error("latch dropped in edge mode without acknowledge");

    // Edge-only mode never remembers an acknowledge
    a_edge_no_memory : assert property
    (
        @(posedge clock) disable iff (!rstn) !level_mode |=> !ack_held_reg
    )
    else $error("acknowledge remembered in edge mode");

    // Level mode: a low pin keeps the request pending
    a_level_low_holds : assert property
    (
        @(posedge clock) disable iff (!rstn) s_level_low |=> latch_reg
    )
    else $error("latch dropped while pin low in level mode");

    // Level mode: an early acknowledge is kept until the pin rises
    a_early_ack_kept : assert property
    (
        @(posedge clock) disable iff (!rstn) s_early_ack |=> ack_held_reg
    )
    else $error("early acknowledge was not remembered");

    // Level mode: acknowledge plus pin high clears the latch
    a_level_release : assert property
    (
        @(posedge clock) disable iff (!rstn) s_level_done |=> !latch_reg
    )
    else $error("latch not released after acknowledge and pin high");

    // Masked requests never reach the priority logic
    a_mask_withholds : assert property
    (
        @(posedge clock) disable iff (!rstn) mask_reg |-> !ext_int_request
    )
    else $error("request presented while masked");

    // Unmasked latch is presented to the priority logic
    a_request_shows : assert property
    (
        @(posedge clock) disable iff (!rstn) (latch_reg && !mask_reg) |-> ext_int_request
    )
    else $error("unmasked latched request not presented");

    // Pending flag follows the latch whatever the mask says
    a_pending_mirrors : assert property
    (
        @(posedge clock) disable iff (!rstn) ext_int_pending_flag == latch_reg
    )
    else $error("pending flag differs from latch");

    // Acknowledge bit reads zero at all times
    a_ack_reads_zero : assert property
    (
        @(posedge clock) disable iff (!rstn) !ext_int_ctrl_status[eil_pkg::ACK_BIT]
    )
    else $error("acknowledge bit read back as one");

    // A control write loads the mask bit
    a_mask_loads : assert property
    (
        @(posedge clock) disable iff (!rstn) cfg_write |=> ext_int_mask == $past(cfg_mask_wdata)
    )
    else $error("mask bit not loaded by control write");

    // A control write loads the sense select
    a_sense_loads : assert property
    (
        @(posedge clock) disable iff (!rstn)
            cfg_write |=> level_sense_select == $past(cfg_level_wdata)
    )
    else $error("sense select not loaded by control write");

    // Trade-off: the pin is seen two clocks late through the synchroniser,
    // so the pin level flag lags the pad by that much and the latch by one clock more; software
    // that polls the level right after a pin change must allow for it.
    // The mask only gates the request; it never stops the latch from
    // recording an edge, so unmasking later still shows the old event.

endmodule : eil_top

// [dv/eil_pin_drv.sv]
`timescale 1ns/1ps
// Far-side device on the pin; idles high with its pull-up
module eil_pin_drv
(
    output logic pin_n
);
    initial pin_n = 1'h1;
    // Called off the sampling edge so the synchroniser sees a clean step
    task automatic drive(input logic v);
        pin_n = v;
    endtask : drive
endmodule : eil_pin_drv

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic clock = 1'h0, rstn = 1'h0, vf = 1'h0, wr = 1'h0, ak = 1'h0, mk = 1'h0, lv = 1'h0;
    logic pin_n, req, pend, sel, msk, pl;
    logic [eil_pkg::STATUS_W-1:0] st;
    int num_errors = 0, n_compared = 0, cyc = 0;
    eil_pin_drv i_eil_pin_drv (.pin_n(pin_n));
    eil_top i_eil_top (.clock(clock), .rstn(rstn), .irq_pin_n(pin_n), .vector_fetch(vf),
        .cfg_write(wr), .cfg_ack_wdata(ak), .cfg_mask_wdata(mk), .cfg_level_wdata(lv),
        .ext_int_request(req), .ext_int_pending_flag(pend), .ext_int_mask(msk),
        .level_sense_select(sel), .pin_level(pl), .ext_int_ctrl_status(st));
    always #50 clock = ~clock;
    // Hang guard, far above the roughly 100 cycles the tests need
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            num_errors++;
            complete_run();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %0t got %b", $time, got);
        end
    endtask : chk
    // One control write, then time for the flags to settle
    task automatic cfg(input logic a, input logic m, input logic l);
        {wr, ak, mk, lv} = {1'h1, a, m, l};
        tick(1);
        {wr, ak} = 2'h0;
        tick(2);
    endtask : cfg
    // Pin step plus room for the two-flop synchroniser
    task automatic pin(input logic v);
        i_eil_pin_drv.drive(v);
        tick(5);
    endtask : pin
    // One-cycle vector fetch acknowledge
    task automatic fetch;
        vf = 1'h1;
        tick(1);
        vf = 1'h0;
        tick(2);
    endtask : fetch
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        tick(20);
        rstn = 1'h1;
        tick(2);
        chk(pend, 1'h0);
        chk(sel, 1'h0);
        chk(pl, 1'h1);
        pin(1'h0);
        chk(pend, 1'h1);
        chk(req, 1'h1);
        chk(pl, 1'h0);
        chk(st[eil_pkg::PENDING_BIT], 1'h1);
        pin(1'h1);
        chk(pend, 1'h1);
        fetch();
        chk(pend, 1'h0);
        // Edge reaches the latch in the same cycle as a vector fetch
        i_eil_pin_drv.drive(1'h0);
        tick(2);
        fetch();
        chk(pend, 1'h1);
        pin(1'h1);
        fetch();
        chk(pend, 1'h0);
        $display("edge test done");
        cfg(1'h0, 1'h1, 1'h0);
        chk(msk, 1'h1);
        chk(st[eil_pkg::MASK_BIT], 1'h1);
        pin(1'h0);
        chk(req, 1'h0);
        chk(pend, 1'h1);
        chk(st[eil_pkg::ACK_BIT], 1'h0);
        pin(1'h1);
        cfg(1'h1, 1'h0, 1'h0);
        chk(pend, 1'h0);
        chk(msk, 1'h0);
        $display("mask test done");
        cfg(1'h0, 1'h0, 1'h1);
        chk(sel, 1'h1);
        chk(st[eil_pkg::SENSE_BIT], 1'h1);
        pin(1'h0);
        cfg(1'h1, 1'h0, 1'h1);
        chk(pend, 1'h1);
        pin(1'h1);
        chk(pend, 1'h0);
        pin(1'h0);
        pin(1'h1);
        chk(pend, 1'h1);
        cfg(1'h1, 1'h0, 1'h1);
        chk(pend, 1'h0);
        pin(1'h0);
        rstn = 1'h0;
        tick(2);
        chk(pend, 1'h0);
        chk(sel, 1'h0);
        $display("level test done");
        complete_run();
    end
endmodule : testbench
